// ===== verif/e1_perf_monitor_counters_tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(what, exp, got) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("BAD %s expected %h seen %h", what, exp, got); \
  end \
end

module e1_perf_monitor_counters_tb;
  localparam int period_cycles = 50;

  logic        core_clk_i = 1'b0;
  logic        srst_i     = 1'b1;
  logic        psel_i     = 1'b0;
  logic        penable_i  = 1'b0;
  logic        pwrite_i   = 1'b0;
  logic [11:0] paddr_i    = 12'h000;
  logic [31:0] pwdata_i   = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [6:0]  ev         = 7'h00;
  logic        strobe     = 1'b0;
  logic        update_pulse_o;
  logic [7:0]  ctrl_val   = 8'h00;
  int          errors     = 0;
  int          cmp_count  = 0;
  int          upd_seen   = 0;

  e1_perf_monitor_counters #(.UPDATE_PERIOD_CYCLES(period_cycles)) i_e1_perf_monitor_counters (
    .core_clk_i               (core_clk_i),
    .srst_i                   (srst_i),
    .psel_i                   (psel_i),
    .penable_i                (penable_i),
    .pwrite_i                 (pwrite_i),
    .paddr_i                  (paddr_i),
    .pwdata_i                 (pwdata_i),
    .prdata_o                 (prdata_o),
    .pready_o                 (pready_o),
    .pslverr_o                (pslverr_o),
    .frame_sync_loss_i        (ev[0]),
    .pattern_detector_error_i (ev[1]),
    .bipolar_violation_i      (ev[2]),
    .hdb3_code_violation_i    (ev[3]),
    .nt_crc_error_i           (ev[4]),
    .far_block_error_i        (ev[5]),
    .nt_far_block_error_i     (ev[6]),
    .second_strobe_i          (strobe),
    .update_pulse_o           (update_pulse_o)
  );

  // Clock at 40 MHz
  always #12.5 core_clk_i = ~core_clk_i;

  // Count group update pulses
  always @(posedge core_clk_i) begin
    if (update_pulse_o === 1'b1) upd_seen++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB master: holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= {2'b00, idx, 2'b00};
    pwdata_i  <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    `CHK("access cycles", 1, n)
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, idx, 32'h0, d, e);
    `CHK(what, exp, d)
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, wd, d, e);
  endtask

  // Manual update: raise the request bit then clear it
  task automatic update();
    wr(perf_monitor_pkg::update_control_idx, {24'h0, ctrl_val | 8'h02});
    wr(perf_monitor_pkg::update_control_idx, {24'h0, ctrl_val});
  endtask

  // Hold an event mask high for n cycles
  task automatic hold(input logic [6:0] mask, input int n);
    @(posedge core_clk_i);
    ev <= mask;
    repeat (n) @(posedge core_clk_i);
    ev <= 7'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    for (int i = 5; i < 16; i++) begin
      rd_chk("reset counter", i[7:0], 32'h0);
    end
    rd_chk("reset control", perf_monitor_pkg::update_control_idx, 32'h0);
    rd_chk("reset status", perf_monitor_pkg::update_status_idx, 32'h0);
  endtask

  task automatic t_counts();
    hold(7'h01, 21);
    hold(7'h02, 4660);
    hold(7'h04, 33000);
    hold(7'h08, 7);
    hold(7'h10, 677);
    hold(7'h20, 346);
    hold(7'h40, 769);
    update();
    rd_chk("frame loss", 8'h05, 32'h15);
    rd_chk("pattern lo", 8'h06, 32'h34);
    rd_chk("pattern hi", 8'h07, 32'h12);
    rd_chk("line viol lo", 8'h08, 32'he8);
    rd_chk("line viol hi", 8'h09, 32'h80);
    rd_chk("nt crc lo", 8'h0a, 32'ha5);
    rd_chk("nt crc hi", 8'h0b, 32'h20);
    rd_chk("far block lo", 8'h0c, 32'h5a);
    rd_chk("far block hi", 8'h0d, 32'h10);
    rd_chk("nt far lo", 8'h0e, 32'h01);
    rd_chk("nt far hi", 8'h0f, 32'h30);
  endtask

  task automatic t_hdb3();
    ctrl_val = 8'h04;
    wr(perf_monitor_pkg::update_control_idx, {24'h0, ctrl_val});
    hold(7'h08, 5);
    hold(7'h04, 9);
    update();
    rd_chk("hdb3 viol lo", 8'h08, 32'h05);
    rd_chk("hdb3 viol hi", 8'h09, 32'h00);
    rd_chk("restarted frame loss", 8'h05, 32'h00);
  endtask

  // Events keep arriving while the snapshot is taken
  task automatic t_coincide();
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] f;
    logic        e;
    fork
      hold(7'h1a, 40);
      begin
        repeat (12) @(posedge core_clk_i);
        update();
        apb(1'b0, 8'h06, 32'h0, a, e);
        apb(1'b0, 8'h0a, 32'h0, c, e);
      end
    join
    update();
    apb(1'b0, 8'h06, 32'h0, b, e);
    apb(1'b0, 8'h0a, 32'h0, f, e);
    `CHK("split total", 32'd40, a + b)
    `CHK("crc split total", 32'd40, c + f)
  endtask

  task automatic t_manual();
    logic [31:0] d;
    logic        e;
    int          base;
    base = upd_seen;
    wr(perf_monitor_pkg::update_control_idx, {24'h0, ctrl_val | 8'h02});
    wr(perf_monitor_pkg::update_control_idx, {24'h0, ctrl_val | 8'h02});
    repeat (4) @(posedge core_clk_i);
    `CHK("one update per rise", base + 1, upd_seen)
    wr(perf_monitor_pkg::update_control_idx, {24'h0, ctrl_val});
    wr(8'h05, 32'hff);
    rd_chk("read-only counter", 8'h05, 32'h00);
    apb(1'b0, 8'h20, 32'h0, d, e);
    `CHK("unmapped data", 32'h0, d)
    `CHK("unmapped error", 1'b1, e)
  endtask

  // Second strobe toggles; updates only appear with auto enable
  task automatic t_auto();
    logic [31:0] d;
    logic        e;
    int          base;
    ctrl_val = 8'h00;
    wr(perf_monitor_pkg::update_control_idx, 32'h0);
    base = upd_seen;
    repeat (8) begin
      repeat (period_cycles / 2) @(posedge core_clk_i);
      strobe <= ~strobe;
    end
    `CHK("no auto update", base, upd_seen)
    hold(7'h01, 3);
    // Quiet strobe: exactly one timer update inside one period and a bit
    wr(perf_monitor_pkg::update_control_idx, 32'h1);
    repeat (period_cycles + 20) @(posedge core_clk_i);
    wr(perf_monitor_pkg::update_control_idx, 32'h0);
    repeat (4) @(posedge core_clk_i);
    `CHK("one update per period", base + 1, upd_seen)
    rd_chk("auto snapshot", perf_monitor_pkg::frame_loss_count_idx, 32'h03);
    wr(perf_monitor_pkg::update_control_idx, 32'h1);
    repeat (8) begin
      repeat (period_cycles / 2) @(posedge core_clk_i);
      strobe <= ~strobe;
    end
    wr(perf_monitor_pkg::update_control_idx, 32'h0);
    repeat (4) @(posedge core_clk_i);
    `CHK("auto update seen", 1'b1, upd_seen > base)
    apb(1'b0, perf_monitor_pkg::update_status_idx, 32'h0, d, e);
    `CHK("update count", upd_seen[15:0], d[15:0])
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog sized above the longest expected run
  initial begin
    repeat (60000) @(posedge core_clk_i);
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_counts();
    t_hdb3();
    t_coincide();
    t_manual();
    t_auto();
    close_out();
  end
endmodule

`default_nettype wire

// ===== verilog/e1_perf_monitor_counters.sv
// Notes on behaviour
// R1: Five-bit frame sync loss count, bits 4:0
// R2: Sixteen-bit pattern detector error count, two bytes
// R3: AMI mode counts bipolar violations
// R4: HDB3 mode counts HDB3 code violations
// R5: Line violation count MSB at high bit 7
// R6: Ten-bit NT CRC error count, low/high
// R7: Ten-bit high byte: bit9 at 5, bit8 at 4
// R8: Ten-bit far end block error count
// R9: Ten-bit NT far end block error count
// R10: Update bit rising edge refreshes all snapshots
// R11: Auto enable refreshes snapshots every second
// R12: Snapshot copies counter, restarts, loses nothing
`timescale 1ns/100ps
`default_nettype none

module e1_perf_monitor_counters #(
  parameter int UPDATE_PERIOD_CYCLES = perf_monitor_pkg::update_period_cycles
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  // Event pulses from the receive framer, same clock
  input  wire logic        frame_sync_loss_i,
  input  wire logic        pattern_detector_error_i,
  input  wire logic        bipolar_violation_i,
  input  wire logic        hdb3_code_violation_i,
  input  wire logic        nt_crc_error_i,
  input  wire logic        far_block_error_i,
  input  wire logic        nt_far_block_error_i,
  // External one-second strobe level, asynchronous
  input  wire logic        second_strobe_i,
  // Status
  output var  logic        update_pulse_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int TICK_W = $clog2(UPDATE_PERIOD_CYCLES + 1);
  localparam int NW = perf_monitor_pkg::narrow_count_w;
  localparam int WW = perf_monitor_pkg::wide_count_w;
  localparam int FW = perf_monitor_pkg::frame_sync_loss_w;

  logic [7:0]        update_control_reg;
  logic              manual_last_reg;
  logic [TICK_W-1:0] tick_count_reg;
  logic              tick;
  logic              ext_tick;
  logic              snap;
  logic              hdb3_mode;
  logic              line_event;
  logic [15:0]       update_count_reg;
  logic [7:0]        reg_index;
  logic              access;
  logic              wr_en;
  logic              mapped;
  logic [31:0]       rd_data;

  logic [FW-1:0] fsl_snap;
  logic [WW-1:0] pat_snap;
  logic [WW-1:0] line_snap;
  logic [NW-1:0] crc_snap;
  logic [NW-1:0] feb_snap;
  logic [NW-1:0] ntf_snap;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: byte address is four times the register index

  assign reg_index = paddr_i[9:2];
  assign access    = psel_i & penable_i;
  assign wr_en     = access & pwrite_i & mapped;

  // Control register: auto enable, manual update, line decode mode
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      update_control_reg <= perf_monitor_pkg::update_control_reset;
    end else if (wr_en && reg_index == perf_monitor_pkg::update_control_idx) begin
      update_control_reg <= {5'h00, pwdata_i[2:0]};
    end
  end

  assign hdb3_mode = update_control_reg[perf_monitor_pkg::line_decode_hdb3_bit];

  ////////////////////////////////////////////////////////////////////////////
  // Update triggers

  // Manual request edge history
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      manual_last_reg <= 1'b0;
    end else begin
      manual_last_reg <= update_control_reg[perf_monitor_pkg::manual_update_request_bit];
    end
  end

  // One second timer, runs only while auto update is enabled
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tick_count_reg <= '0;
    end else if (!update_control_reg[perf_monitor_pkg::auto_update_enable_bit]) begin
      tick_count_reg <= '0;
    end else if (tick) begin
      tick_count_reg <= '0;
    end else begin
      tick_count_reg <= tick_count_reg + TICK_W'(1);
    end
  end

  assign tick = update_control_reg[perf_monitor_pkg::auto_update_enable_bit] &&
                tick_count_reg == TICK_W'(UPDATE_PERIOD_CYCLES - 1); // [R11]

  // Optional external second strobe, synchronised
  pulse_sync u_second_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    (second_strobe_i),
    .pulse_o    (ext_tick)
  );

  // Group snapshot strobe
  assign snap = (update_control_reg[perf_monitor_pkg::manual_update_request_bit] &
                 ~manual_last_reg) // [R10]
              | tick
              | (ext_tick & update_control_reg[perf_monitor_pkg::auto_update_enable_bit]);

  // Update counter and status pulse
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      update_count_reg <= 16'h0000;
      update_pulse_o   <= 1'b0;
    end else begin
      update_pulse_o <= snap;
      if (snap) begin
        update_count_reg <= update_count_reg + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  // Line violation source follows the decoder mode
  assign line_event = hdb3_mode ? hdb3_code_violation_i // [R4]
                                : bipolar_violation_i;  // [R3]

  event_counter #(.WIDTH(FW)) u_fsl ( // [R1]
    .core_clk_i   (core_clk_i),
    .srst_i       (srst_i),
    .event_i      (frame_sync_loss_i),
    .snap_i       (snap),
    .count_o      (),
    .snap_value_o (fsl_snap)
  );

  event_counter #(.WIDTH(WW)) u_pat ( // [R2]
    .core_clk_i   (core_clk_i),
    .srst_i       (srst_i),
    .event_i      (pattern_detector_error_i),
    .snap_i       (snap),
    .count_o      (),
    .snap_value_o (pat_snap)
  );

  event_counter #(.WIDTH(WW)) u_line (
    .core_clk_i   (core_clk_i),
    .srst_i       (srst_i),
    .event_i      (line_event),
    .snap_i       (snap),
    .count_o      (),
    .snap_value_o (line_snap)
  );

  event_counter #(.WIDTH(NW)) u_crc ( // [R6]
    .core_clk_i   (core_clk_i),
    .srst_i       (srst_i),
    .event_i      (nt_crc_error_i),
    .snap_i       (snap),
    .count_o      (),
    .snap_value_o (crc_snap)
  );

  event_counter #(.WIDTH(NW)) u_feb ( // [R8]
    .core_clk_i   (core_clk_i),
    .srst_i       (srst_i),
    .event_i      (far_block_error_i),
    .snap_i       (snap),
    .count_o      (),
    .snap_value_o (feb_snap)
  );

  event_counter #(.WIDTH(NW)) u_ntf ( // [R9]
    .core_clk_i   (core_clk_i),
    .srst_i       (srst_i),
    .event_i      (nt_far_block_error_i),
    .snap_i       (snap),
    .count_o      (),
    .snap_value_o (ntf_snap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  // Selects snapshot bytes; reserved bits read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    mapped  = 1'b1;
    unique case (reg_index)
      perf_monitor_pkg::frame_loss_count_idx:
        rd_data[FW-1:0] = fsl_snap; // [R1]
      perf_monitor_pkg::pattern_error_count_lo_idx:
        rd_data[7:0] = pat_snap[7:0]; // [R2]
      perf_monitor_pkg::pattern_error_count_hi_idx:
        rd_data[7:0] = pat_snap[15:8]; // [R2]
      perf_monitor_pkg::line_violation_count_lo_idx:
        rd_data[7:0] = line_snap[7:0];
      perf_monitor_pkg::line_violation_count_hi_idx:
        rd_data[7:0] = line_snap[15:8]; // [R5]
      perf_monitor_pkg::nt_crc_error_count_lo_idx:
        rd_data[7:0] = crc_snap[7:0]; // [R6]
      perf_monitor_pkg::nt_crc_error_count_hi_idx:
        rd_data[perf_monitor_pkg::narrow_hi_lsb +: 2] = crc_snap[9:8]; // [R7]
      perf_monitor_pkg::far_block_error_count_lo_idx:
        rd_data[7:0] = feb_snap[7:0]; // [R8]
      perf_monitor_pkg::far_block_error_count_hi_idx:
        rd_data[perf_monitor_pkg::narrow_hi_lsb +: 2] = feb_snap[9:8]; // [R7]
      perf_monitor_pkg::nt_far_block_error_count_lo_idx:
        rd_data[7:0] = ntf_snap[7:0]; // [R9]
      perf_monitor_pkg::nt_far_block_error_count_hi_idx:
        rd_data[perf_monitor_pkg::narrow_hi_lsb +: 2] = ntf_snap[9:8]; // [R7]
      perf_monitor_pkg::update_control_idx:
        rd_data[7:0] = update_control_reg;
      perf_monitor_pkg::update_status_idx:
        rd_data[15:0] = update_count_reg;
      default:
        mapped = 1'b0;
    endcase
    if (paddr_i[11:10] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // Registered APB answer: ready in the first access cycle, zero wait states
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      prdata_o  <= (psel_i & ~penable_i & ~pwrite_i & mapped) ? rd_data : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  chk_manual_edge_snap: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R10]
    $rose(update_control_reg[perf_monitor_pkg::manual_update_request_bit]) |-> snap)
    else $error("Manual update edge did not refresh snapshots");

  chk_auto_off_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R11]
    !update_control_reg[perf_monitor_pkg::auto_update_enable_bit] |-> !tick)
    else $error("Timer tick while auto update disabled");

  chk_tick_count_ok: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R11]
    tick |=> tick_count_reg == '0)
    else $error("Timer did not restart after tick");

  chk_line_hdb3_src: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R4]
    hdb3_mode |-> line_event == hdb3_code_violation_i)
    else $error("HDB3 mode uses wrong violation source");

  chk_line_ami_src: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R3]
    !hdb3_mode |-> line_event == bipolar_violation_i)
    else $error("AMI mode uses wrong violation source");

  chk_snap_line_copy: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R12]
    snap |=> line_snap == $past(u_line.count_reg))
    else $error("Line violation snapshot mismatch");

  chk_snap_restart: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R12]
    snap && !frame_sync_loss_i |=> u_fsl.count_reg == '0)
    else $error("Counter did not restart on snapshot");

  chk_snap_keep_event: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R12]
    snap && nt_crc_error_i |=> u_crc.count_reg == NW'(1))
    else $error("Event lost during snapshot");

  chk_hi_byte_place: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R7]
    reg_index == perf_monitor_pkg::far_block_error_count_hi_idx |->
      rd_data[5:4] == feb_snap[9:8] && rd_data[3:0] == 4'h0)
    else $error("Ten-bit high byte misplaced");

  chk_apb_ready: assert property (@(posedge core_clk_i) disable iff (srst_i)
    psel_i && !penable_i |=> pready_o)
    else $error("APB ready not given after setup");

  chk_pready_one_cycle: assert property (@(posedge core_clk_i) disable iff (srst_i)
    pready_o |=> !pready_o)
    else $error("APB ready stood longer than one cycle");

  chk_unmapped_error: assert property (@(posedge core_clk_i) disable iff (srst_i)
    psel_i && !penable_i && !mapped |=> pslverr_o)
    else $error("Unmapped access gave no error");

  chk_fsl_reserved_zero: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R1]
    reg_index == perf_monitor_pkg::frame_loss_count_idx |->
      rd_data[31:FW] == '0 && rd_data[FW-1:0] == fsl_snap)
    else $error("Frame loss count misplaced");

  chk_line_hi_msb: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R5]
    reg_index == perf_monitor_pkg::line_violation_count_hi_idx |->
      rd_data[7:0] == line_snap[15:8])
    else $error("Line violation high byte misplaced");

  chk_tick_bound: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R11]
    tick_count_reg <= TICK_W'(UPDATE_PERIOD_CYCLES - 1))
    else $error("Second timer ran past its period");

  chk_snap_ntf_copy: assert property (@(posedge core_clk_i) disable iff (srst_i) // [R9]
    snap |=> ntf_snap == $past(u_ntf.count_reg))
    else $error("NT far end snapshot mismatch");

  chk_update_pulse: assert property (@(posedge core_clk_i) disable iff (srst_i)
    snap |=> update_pulse_o)
    else $error("Update pulse missing after snapshot");

  cov_manual_update: cover property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(update_control_reg[perf_monitor_pkg::manual_update_request_bit]));
  cov_auto_tick: cover property (@(posedge core_clk_i) disable iff (srst_i) tick);
  cov_snap_with_event: cover property (@(posedge core_clk_i) disable iff (srst_i)
    snap && line_event);
  cov_ext_update: cover property (@(posedge core_clk_i) disable iff (srst_i)
    ext_tick && update_control_reg[perf_monitor_pkg::auto_update_enable_bit]);

endmodule

`default_nettype wire

// ===== verilog/event_counter.sv
`timescale 1ns/100ps
`default_nettype none

// Saturating event counter that restarts on a snapshot, keeping a coincident event
module event_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  // Event and snapshot
  input  wire logic             event_i,
  input  wire logic             snap_i,
  output var  logic [WIDTH-1:0] count_o,
  output var  logic [WIDTH-1:0] snap_value_o
);

  logic [WIDTH-1:0] count_reg;
  logic             full;

  assign full = &count_reg;
  assign count_o = count_reg;

  // Running count; an event in the snapshot cycle becomes the new first count
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      count_reg <= '0;
    end else if (snap_i) begin
      count_reg <= event_i ? WIDTH'(1) : '0; // [R12]
    end else if (event_i && !full) begin
      count_reg <= count_reg + WIDTH'(1);
    end
  end

  // Snapshot register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      snap_value_o <= '0;
    end else if (snap_i) begin
      snap_value_o <= count_reg; // [R12]
    end
  end

endmodule

`default_nettype wire

// ===== verilog/perf_monitor_pkg.sv
`default_nettype none

package perf_monitor_pkg;

  // Register offsets (byte address = 4 * index)
  localparam logic [7:0] frame_loss_count_idx            = 8'h05;
  localparam logic [7:0] pattern_error_count_lo_idx      = 8'h06;
  localparam logic [7:0] pattern_error_count_hi_idx      = 8'h07;
  localparam logic [7:0] line_violation_count_lo_idx     = 8'h08;
  localparam logic [7:0] line_violation_count_hi_idx     = 8'h09;
  localparam logic [7:0] nt_crc_error_count_lo_idx       = 8'h0a;
  localparam logic [7:0] nt_crc_error_count_hi_idx       = 8'h0b;
  localparam logic [7:0] far_block_error_count_lo_idx    = 8'h0c;
  localparam logic [7:0] far_block_error_count_hi_idx    = 8'h0d;
  localparam logic [7:0] nt_far_block_error_count_lo_idx = 8'h0e;
  localparam logic [7:0] nt_far_block_error_count_hi_idx = 8'h0f;
  localparam logic [7:0] update_control_idx              = 8'h10;
  localparam logic [7:0] update_status_idx               = 8'h11;

  // Update control field positions
  localparam int auto_update_enable_bit    = 0;
  localparam int manual_update_request_bit = 1;
  localparam int line_decode_hdb3_bit      = 2;
  localparam logic [7:0] update_control_reset = 8'h00;

  // Counter widths
  localparam int frame_sync_loss_w = 5;
  localparam int wide_count_w      = 16;
  localparam int narrow_count_w    = 10;

  // High byte placement of ten-bit counters
  localparam int narrow_hi_lsb = 4;

  // One second tick
  localparam int clk_freq_hz     = 40_000_000;
  localparam int update_period_s = 1;
  localparam int update_period_cycles = clk_freq_hz * update_period_s;

endpackage

`default_nettype wire

// ===== verilog/pulse_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two flip-flop synchroniser followed by a rising edge detector
module pulse_sync (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // Asynchronous level in, synchronous pulse out
  input  wire logic async_i,
  output var  logic pulse_o
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Synchroniser and edge history
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign pulse_o = sync_reg & ~last_reg;

endmodule

`default_nettype wire
